// [inc/led_fault_pkg.sv]
package led_fault_pkg;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned TMO_WIDTH      = 5;
  // Timeout in dimming cycles; phase-shift mode
  localparam logic [4:0]  TMO_PWM_CYCLES = 5'h06;
  // Direct PWM mode: window 7..18, we fault at the upper end for margin
  localparam logic [4:0]  TMO_DIR_MIN    = 5'h07;
  localparam logic [4:0]  TMO_DIR_CYCLES = 5'h12;
  localparam real         CLK_MHZ        = 10.0;
  localparam logic [3:0]  ALL_ON         = 4'hf;
  localparam logic [3:0]  ALL_OFF        = 4'h0;
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_LOCK} run_state_t;
endpackage

// [src/chan_timeout.sv]
`timescale 1ns/1ps
module chan_timeout
  import led_fault_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       fault_cond,
  input  wire logic       pwm_tick,
  input  wire logic [4:0] limit,
  output logic            faulted
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       faulted_q;
  logic       faulted_d;

  always_comb
  begin
    cnt_d     = cnt_q;
    faulted_d = faulted_q;
    if (clr)
    begin
      cnt_d     = 5'h00;
      faulted_d = 1'b0;
    end
    else if (!fault_cond)
      cnt_d = 5'h00;
    else if (pwm_tick && !faulted_q)
    begin
      cnt_d = cnt_q + 5'h01;
      if (cnt_d >= limit)
        faulted_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q     <= 5'h00;
      faulted_q <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_d;
      faulted_q <= faulted_d;
    end
  end

  assign faulted = faulted_q;
endmodule

// [src/led_channel_fault_supervisor.sv]
`timescale 1ns/1ps
// How it works
// - Supply undervoltage halts boosting and holds the control logic in reset.
// - After undervoltage, running resumes only on a fresh enable rise with the supply in range.
// - Over-temperature stops boosting and turns off every current sink.
// - A channel below the short threshold stays on and the others regulate as usual.
// - Over-temperature with an open or not-yet-good channel below threshold turns all channels off until enable falls or undervoltage.
// - A channel above the short threshold faults out after 6 dimming cycles, or 18 in direct mode.
// - An open channel lets output rise to overvoltage then faults out after the same timeout.
// - A zener-bypassed open channel stays on and leads regulation by its higher forward voltage.
// - Over-temperature with a bypassed channel turns that channel and all others off.
// - Any channel pushed above the short threshold by a raised output faults out after the timeout.
// - Over-temperature with all channels below threshold turns all off until it clears.
// - At overvoltage channels keep normal current and channels not good time out.
// - A channel becomes good at target current; a later drop or overvoltage before good means open.
// - A floating frequency-set pin selects direct dimming with no phase shift and the long timeout.
module led_channel_fault_supervisor
  import led_fault_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                enable_in,
  input  wire logic                supply_undervoltage_flag,
  input  wire logic                over_temp_flag,
  input  wire logic                output_overvoltage_flag,
  input  wire logic [NUM_CH-1:0]   chan_above_short,
  input  wire logic [NUM_CH-1:0]   chan_current_good,
  input  wire logic                dim_pwm_in,
  input  wire logic                dim_freq_set_pin_floating,
  output logic      [NUM_CH-1:0]   led_channel_n_en,
  output logic      [NUM_CH-1:0]   regulation_select,
  output logic      [NUM_CH-1:0]   chan_faulted,
  output logic                     boost_enable,
  output logic                     direct_pwm_mode,
  output logic                     phase_shift_en
);
  // Two-flop synchronisers for every analog-side input
  localparam int unsigned SW = 6 + 2 * NUM_CH;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= {enable_in, supply_undervoltage_flag, over_temp_flag, output_overvoltage_flag,
               dim_pwm_in, dim_freq_set_pin_floating, chan_above_short, chan_current_good};
      s2_q <= s1_q;
    end
  end

  logic              en_s;
  logic              uv_s;
  logic              ot_s;
  logic              ov_s;
  logic              pwm_s;
  logic              float_s;
  logic [NUM_CH-1:0] short_s;
  logic [NUM_CH-1:0] cgood_s;
  assign {en_s, uv_s, ot_s, ov_s, pwm_s, float_s, short_s, cgood_s} = s2_q;

  // Main run state and edge history
  run_state_t        st_q;
  run_state_t        st_d;
  logic              en_prev_q;
  logic              pwm_prev_q;
  logic              mode_q;
  logic              mode_d;
  logic [NUM_CH-1:0] good_q;
  logic [NUM_CH-1:0] good_d;
  logic [NUM_CH-1:0] open_q;
  logic [NUM_CH-1:0] open_d;
  logic              chan_clr;
  logic              pwm_tick;
  logic              en_rise;

  assign pwm_tick = pwm_s & ~pwm_prev_q;
  assign en_rise  = en_s & ~en_prev_q;

  always_comb
  begin
    st_d   = st_q;
    mode_d = mode_q;
    case (st_q)
      ST_OFF:
        if (en_rise && !uv_s)
        begin
          st_d   = ST_RUN;
          mode_d = float_s;
        end
      ST_RUN:
        if (uv_s)
          st_d = ST_OFF;
        else if (!en_s)
          st_d = ST_OFF;
        // A channel that lost its current after being good counts as not good here
        else if (ot_s && (|(~short_s & ~chan_faulted & (~good_q | open_q))))
          st_d = ST_LOCK;
      ST_LOCK:
        if (uv_s || !en_s)
          st_d = ST_OFF;
      default:
        st_d = ST_OFF;
    endcase
  end

  // Control logic is held cleared in ST_OFF and during undervoltage
  assign chan_clr = (st_q == ST_OFF) || uv_s;

  always_comb
  begin
    good_d = good_q;
    open_d = open_q;
    if (chan_clr)
    begin
      good_d = '0;
      open_d = '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (cgood_s[i])
        begin
          good_d[i] = 1'b1;
          open_d[i] = 1'b0;
        end
        else if (good_q[i])
          open_d[i] = 1'b1;
        if (ov_s && !good_q[i] && !cgood_s[i])
          open_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q       <= ST_OFF;
      en_prev_q  <= 1'b1; // Reset high, but en_s resets low, so enable held high at power-up still reads as a fresh enable
      pwm_prev_q <= 1'b0;
      mode_q     <= 1'b0;
      good_q     <= '0;
      open_q     <= '0;
    end
    else
    begin
      st_q       <= st_d;
      en_prev_q  <= en_s;
      pwm_prev_q <= pwm_s;
      mode_q     <= mode_d;
      good_q     <= good_d;
      open_q     <= open_d;
    end
  end

  logic [4:0] tmo_limit;
  assign tmo_limit = mode_q ? TMO_DIR_CYCLES : TMO_PWM_CYCLES;

  // One timeout per channel; short and open share the same timer
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    chan_timeout u_tmo (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .clr        (chan_clr),
      .fault_cond (short_s[g] | open_q[g]),
      .pwm_tick   (pwm_tick),
      .limit      (tmo_limit),
      .faulted    (chan_faulted[g])
    );
  end

  // Outputs, all registered
  logic [NUM_CH-1:0] en_out_q;
  logic [NUM_CH-1:0] en_out_d;
  logic [NUM_CH-1:0] reg_q;
  logic [NUM_CH-1:0] reg_d;
  logic              boost_q;
  logic              boost_d;

  always_comb
  begin
    en_out_d = ALL_OFF;
    boost_d  = 1'b0;
    if (st_q == ST_RUN && !uv_s)
    begin
      if (ot_s)
        en_out_d = ALL_OFF;
      else
      begin
        en_out_d = ALL_ON & ~chan_faulted;
        boost_d  = 1'b1;
      end
    end
    // Regulation follows every live channel; the analog side picks the highest forward voltage
    reg_d = en_out_d;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      en_out_q <= ALL_OFF;
      reg_q    <= ALL_OFF;
      boost_q  <= 1'b0;
    end
    else
    begin
      en_out_q <= en_out_d;
      reg_q    <= reg_d;
      boost_q  <= boost_d;
    end
  end

  assign led_channel_n_en  = en_out_q;
  assign regulation_select = reg_q;
  assign boost_enable      = boost_q;
  assign direct_pwm_mode   = mode_q;
  assign phase_shift_en    = ~mode_q;
endmodule

// [test/led_channel_fault_supervisor_asserts.sv]
`timescale 1ns/1ps
module led_sup_asserts
  import led_fault_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       enable_in,
  input wire logic       supply_undervoltage_flag,
  input wire logic       over_temp_flag,
  input wire logic [3:0] chan_above_short,
  input wire logic [3:0] chan_current_good,
  input wire logic [3:0] led_channel_n_en,
  input wire logic [3:0] regulation_select,
  input wire logic [3:0] chan_faulted,
  input wire logic       boost_enable,
  input wire logic       direct_pwm_mode,
  input wire logic       phase_shift_en
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Cause may still sit in the sync pipe
  wire logic [3:0] cnd = chan_above_short | ~chan_current_good;
  sequence s_steady;
    (enable_in && !supply_undervoltage_flag)[*5];
  endsequence
  sequence s_start;
    !enable_in[*4] ##1 (enable_in && !supply_undervoltage_flag && !over_temp_flag)[*6];
  endsequence
  chk_uv_halt:
    assert property ($rose(supply_undervoltage_flag) |-> ##[1:4] !boost_enable) else $error("uv boost");
  chk_hot_off:
    assert property (over_temp_flag[*4] |-> !boost_enable && led_channel_n_en == ALL_OFF) else $error("hot");
  chk_start_run:
    assert property (s_start |-> boost_enable) else $error("no start");
  chk_fault_hold:
    assert property (s_steady |-> (chan_faulted & $past(chan_faulted)) == $past(chan_faulted)) else $error("unlatch");
  chk_sink_off:
    assert property (($past(chan_faulted) & led_channel_n_en) == ALL_OFF) else $error("sink on");
  chk_fault_cause:
    assert property ((chan_faulted & ~$past(chan_faulted) & ~($past(cnd, 3) | $past(cnd, 4))) == ALL_OFF)
      else $error("no cause");
  chk_reg_follow:
    assert property (regulation_select == led_channel_n_en) else $error("regulation");
  chk_mode_phase:
    assert property (phase_shift_en == !direct_pwm_mode) else $error("phase");
endmodule
bind led_channel_fault_supervisor led_sup_asserts i_led_sup_asserts (.*);

// [test/led_channel_fault_supervisor_tb_top.sv]
`timescale 1ns/1ps
module led_channel_fault_supervisor_tb_top;
  import led_fault_pkg::*;
  logic       clk_sys = 1'b0, rstn = 1'b0, enable_in = 1'b0, dim_pwm_in;
  logic       supply_undervoltage_flag = 1'b0, over_temp_flag = 1'b0;
  logic       output_overvoltage_flag = 1'b0, dim_freq_set_pin_floating = 1'b0;
  logic       boost_enable, direct_pwm_mode, phase_shift_en;
  logic [3:0] short_mask = 4'h0, open_mask = 4'h0, chan_above_short, chan_current_good;
  logic [3:0] led_channel_n_en, regulation_select, chan_faulted;
  int         error_cnt = 0, comparisons = 0, k;
  led_plant_model i_led_plant_model (.*);
  led_channel_fault_supervisor i_led_channel_fault_supervisor (.*);
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [3:0] a, input logic [3:0] e, input string m);
    comparisons++;
    if (a !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  function automatic logic [3:0] fl();
    return {1'b0, boost_enable, direct_pwm_mode, phase_shift_en};
  endfunction
  function automatic int tmo(input logic f);
    return f ? int'(TMO_DIR_CYCLES) : int'(TMO_PWM_CYCLES);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic start(input logic f);
    enable_in = 1'b0;
    dim_freq_set_pin_floating = f;
    short_mask = 4'h0;
    open_mask = 4'h0;
    output_overvoltage_flag = 1'b0;
    cyc(4);
    enable_in = 1'b1;
    cyc(6);
    chk(fl(), {2'b01, f, !f}, "start");
  endtask
  task automatic short_test(input logic f);
    start(f);
    k = $urandom % 4;
    short_mask = 4'h1 << k;
    cyc((tmo(f) - 1) * 8);
    chk(chan_faulted, 4'h0, "early");
    cyc(24);
    chk(chan_faulted, short_mask, "late");
    chk(led_channel_n_en, ~short_mask, "rest");
    chk(regulation_select, ~short_mask, "reg");
    $display("short test done");
  endtask
  initial
  begin
    k = $urandom(32'h60e4);
    cyc(4);
    rstn = 1'b1;
    short_test(1'b0);
    short_test(1'b1);
    supply_undervoltage_flag = 1'b1;
    cyc(6);
    chk({3'h0, boost_enable} | chan_faulted | led_channel_n_en, 4'h0, "uv");
    supply_undervoltage_flag = 1'b0;
    cyc(10);
    chk({3'h0, boost_enable}, 4'h0, "refuse");
    $display("uv test done");
    start(1'b0);
    k = $urandom % 4;
    open_mask = 4'h1 << k;
    output_overvoltage_flag = 1'b1;
    cyc(64);
    chk(chan_faulted, open_mask, "open");
    chk(led_channel_n_en, ~open_mask, "ovp");
    $display("open test done");
    start(1'b0);
    over_temp_flag = 1'b1;
    cyc(5);
    chk(fl() | led_channel_n_en, 4'h1, "hot");
    over_temp_flag = 1'b0;
    cyc(5);
    chk(led_channel_n_en, ALL_ON, "cool");
    open_mask = 4'h1 << k;
    cyc(2);
    over_temp_flag = 1'b1;
    cyc(5);
    over_temp_flag = 1'b0;
    cyc(10);
    chk(fl() | led_channel_n_en, 4'h1, "lock");
    $display("heat test done");
    summarize();
  end
  initial
  begin
    // Run needs about 400 cycles; allow 1000
    #100000;
    error_cnt++;
    summarize();
  end
endmodule

// [test/led_plant_model.sv]
`timescale 1ns/1ps
module led_plant_model
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] short_mask,
  input  wire logic [3:0] open_mask,
  output logic            dim_pwm_in,
  output logic      [3:0] chan_above_short,
  output logic      [3:0] chan_current_good
);
  logic [2:0] ph_q = 3'h0;
  // Eight-clock dimming period keeps timeouts brief
  always @(negedge clk_sys)
  begin
    ph_q <= ph_q + 3'h1;
  end
  assign dim_pwm_in = ph_q[2];
  // An open string carries no current; a shorted one still does
  assign chan_current_good = ~open_mask;
  assign chan_above_short = short_mask;
endmodule
